// ==== hw/ssp_baud_gen.sv ====
`default_nettype none
module ssp_baud_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             restart,
  input  wire logic [1:0]       prescaleSel,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             syncMode,
  output logic                  bitTick
);
  // ****************************************
  // prescaler, divisor and bit counters
  // ****************************************
  logic [5:0]       preCnt_reg, preCnt_next;
  logic [DIV_W-1:0] divCnt_reg, divCnt_next;
  logic [4:0]       bitCnt_reg, bitCnt_next;
  logic             tick_reg, tick_next;
  logic [5:0]       preTop;
  logic [4:0]       bitTop;

  always_comb
  begin
    preTop = 6'((1 << (ssp_pkg::PRESCALE_STEP_SHIFT * prescaleSel)) - 1);
    bitTop = syncMode ? ssp_pkg::SYNC_TICKS_PER_BIT
                      : ssp_pkg::ASYNC_TICKS_PER_BIT;
    preCnt_next = preCnt_reg;
    divCnt_next = divCnt_reg;
    bitCnt_next = bitCnt_reg;
    tick_next   = 1'b0;
    if (restart)
    begin
      preCnt_next = '0;
      divCnt_next = '0;
      bitCnt_next = '0;
    end
    else if (preCnt_reg >= preTop)
    begin
      preCnt_next = '0;
      if (divCnt_reg >= divisor)
      begin
        divCnt_next = '0;
        if (bitCnt_reg >= bitTop)
        begin
          bitCnt_next = '0;
          tick_next   = 1'b1;
        end
        else
          bitCnt_next = bitCnt_reg + 5'h01;
      end
      else
        divCnt_next = divCnt_reg + 1'b1;
    end
    else
      preCnt_next = preCnt_reg + 6'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      preCnt_reg <= '0;
      divCnt_reg <= '0;
      bitCnt_reg <= '0;
      tick_reg   <= 1'b0;
    end
    else
    begin
      preCnt_reg <= preCnt_next;
      divCnt_reg <= divCnt_next;
      bitCnt_reg <= bitCnt_next;
      tick_reg   <= tick_next;
    end
  end

  assign bitTick = tick_reg;
endmodule
`default_nettype wire

// ==== hw/ssp_pkg.sv ====
`default_nettype none
package ssp_pkg;
  // ****************************************
  // status register bit positions
  // ****************************************
  localparam int STAT_TX_DATA_EMPTY_FLAG_BIT = 7;
  localparam int STAT_RX_FULL_FLAG_BIT = 6;
  localparam int STAT_PER_BIT  = 3;
  localparam int STAT_TX_END_FLAG_BIT = 2;
  localparam int STAT_MPB_BIT  = 1;
  localparam int STAT_TX_MULTIPROC_BIT_BIT = 0;
  // ****************************************
  // pin control register bit positions
  // ****************************************
  localparam int PIN_CLK_DIR_BIT  = 3;
  localparam int PIN_CLK_DATA_BIT = 2;
  localparam int PIN_TXD_DIR_BIT  = 1;
  localparam int PIN_BRK_DATA_BIT = 0;
  localparam logic [3:0] PIN_CTL_RESET    = 4'h0;
  localparam logic [3:0] PIN_RSVD_READ    = 4'h0;
  localparam logic [7:0] BAUD_DIV_RESET   = 8'hFF;
  localparam logic [7:0] RX_DATA_RESET    = 8'h00;
  // ****************************************
  // baud timing: last base tick count per bit (ticks per bit minus one)
  // ****************************************
  localparam logic [4:0] ASYNC_TICKS_PER_BIT = 5'h1F;
  localparam logic [4:0] SYNC_TICKS_PER_BIT  = 5'h03;
  localparam int PRESCALE_STEP_SHIFT = 2;
endpackage
`default_nettype wire

// ==== hw/ssp_status_port.sv ====
// Contract
// - Set parity error when received ones plus parity disagree with setting.
// - Parity error still loads data, no receive-full; halts receive, sync transmit.
// - Parity error clears on reset, standby, or write 0 after read 1.
// - Receive enable low leaves parity error unchanged.
// - Transmit end sets on reset, standby, TE low, last bit with empty.
// - Transmit end clears on empty-flag clear or transmit data write.
// - Transmit end is read-only.
// - Async multiprocessor receive captures multiprocessor bit, read-only, reset 0.
// - Receive enable low keeps received multiprocessor bit.
// - Transmit multiprocessor bit appended only in async multiprocessor transmit.
// - Pin register readable, writable; power-on clears; manual reset, standby keep.
// - Pin register bits 7..4 read zero; software writes zero.
// - Clock pin driven with clock data when clock direction set.
// - Clock data read returns live clock pin level.
// - Transmit direction set drives break data onto transmit pin.
// - Receive pin level readable regardless of transmit direction.
// - Baud divisor readable, writable; all ones on reset and standby.
// - Bit time is 32 or 4 base ticks of 4^n times (N+1).
// - Divisor spans 0..255; prescale index selects one of four sources.
// - Each channel instance owns its baud generator and divisor.
// - Receive-full sets when a character arrives without error.
`default_nettype none
module ssp_status_port #(
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              manualReset,
  input  wire logic              standby,
  input  wire logic              statusRead,
  input  wire logic              statusWrite,
  input  wire logic [7:0]        statusWrData,
  output logic [7:0]             statusRdData,
  input  wire logic              pinCtlWrite,
  input  wire logic [7:0]        pinCtlWrData,
  output logic [7:0]             pinCtlRdData,
  input  wire logic              baudWrite,
  input  wire logic [7:0]        baudWrData,
  output logic [7:0]             baudDivisor,
  input  wire logic              syncMode,
  input  wire logic              parityEnable,
  input  wire logic              oddParity,
  input  wire logic              multiprocMode,
  input  wire logic [1:0]        prescaleSel,
  input  wire logic              receiveEnableCtl,
  input  wire logic              transmitEnableCtl,
  input  wire logic              rxCharDone,
  input  wire logic [DATA_W-1:0] rxShiftData,
  input  wire logic              rxParityBit,
  input  wire logic              rxMpBitIn,
  input  wire logic              txDataWrite,
  input  wire logic              txLoad,
  input  wire logic              txLastBit,
  output logic [DATA_W-1:0]      rxDataReg,
  output logic                   rxHalt,
  output logic                   txHalt,
  output logic                   txMpBitOut,
  output logic                   baudTick,
  input  wire logic              sckIn,
  output logic                   sckOut,
  output logic                   sckOe,
  input  wire logic              rxdIn,
  output logic                   txdOut,
  output logic                   txdOe
);
  // ****************************************
  // status flags
  // ****************************************
  logic              per_reg, per_next, tx_end_flag_reg, tx_end_flag_next;
  logic              tx_data_empty_flag_reg, tx_data_empty_flag_next, rx_full_flag_reg, rx_full_flag_next;
  logic              mpb_reg, mpb_next, tx_multiproc_bit_reg, tx_multiproc_bit_next;
  logic              perArm_reg, perArm_next, tdreArm_reg, tdreArm_next;
  logic              rdrfArm_reg, rdrfArm_next;
  logic [DATA_W-1:0] rxData_reg, rxData_next;
  logic              rxHalt_reg, rxHalt_next, txHalt_reg, txHalt_next;
  logic              mpOut_reg, mpOut_next;
  logic              flagInit, charTaken, parityBad;
  logic              perClr, tdreClr, rdrfClr;

  always_comb
  begin
    flagInit  = manualReset || standby;
    charTaken = rxCharDone && receiveEnableCtl && !per_reg;
    parityBad = !syncMode && parityEnable &&
                ((^rxShiftData ^ rxParityBit) != oddParity);
    perClr  = statusWrite && perArm_reg &&
              !statusWrData[ssp_pkg::STAT_PER_BIT];
    tdreClr = statusWrite && tdreArm_reg &&
              !statusWrData[ssp_pkg::STAT_TX_DATA_EMPTY_FLAG_BIT];
    rdrfClr = statusWrite && rdrfArm_reg &&
              !statusWrData[ssp_pkg::STAT_RX_FULL_FLAG_BIT];
    perArm_next  = statusRead ? per_reg  : (statusWrite ? 1'b0 : perArm_reg);
    tdreArm_next = statusRead ? tx_data_empty_flag_reg : (statusWrite ? 1'b0 : tdreArm_reg);
    rdrfArm_next = statusRead ? rx_full_flag_reg : (statusWrite ? 1'b0 : rdrfArm_reg);
    // receive enable gates only the set, through charTaken; set beats clear
    per_next = (charTaken && parityBad) ? 1'b1 :
               (perClr ? 1'b0 : per_reg);
    rxData_next = charTaken ? rxShiftData : rxData_reg;
    rx_full_flag_next = (charTaken && !parityBad) ? 1'b1 :
                (rdrfClr ? 1'b0 : rx_full_flag_reg);
    mpb_next = (charTaken && !syncMode && multiprocMode) ? rxMpBitIn : mpb_reg;
    // transmit empty follows the same set-wins policy
    tx_data_empty_flag_next = (!transmitEnableCtl || txLoad) ? 1'b1 :
                ((tdreClr || txDataWrite) ? 1'b0 : tx_data_empty_flag_reg);
    tx_end_flag_next = (!transmitEnableCtl || (txLastBit && tx_data_empty_flag_reg)) ? 1'b1 :
                ((tdreClr || txDataWrite) ? 1'b0 : tx_end_flag_reg);
    // only the multiprocessor transmit bit is writable
    tx_multiproc_bit_next = statusWrite ? statusWrData[ssp_pkg::STAT_TX_MULTIPROC_BIT_BIT] : tx_multiproc_bit_reg;
    rxHalt_next = per_next;
    txHalt_next = per_next && syncMode;
    // appended bit only when it applies
    mpOut_next = tx_multiproc_bit_reg && !syncMode && multiprocMode && transmitEnableCtl;
    if (flagInit)
    begin
      per_next     = 1'b0;
      rx_full_flag_next    = 1'b0;
      tx_data_empty_flag_next    = 1'b1;
      tx_end_flag_next    = 1'b1;
      perArm_next  = 1'b0;
      tdreArm_next = 1'b0;
      rdrfArm_next = 1'b0;
      rxHalt_next  = 1'b0;
      txHalt_next  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      per_reg     <= 1'b0;
      rx_full_flag_reg    <= 1'b0;
      tx_data_empty_flag_reg    <= 1'b1;
      tx_end_flag_reg    <= 1'b1;
      mpb_reg     <= 1'b0;
      tx_multiproc_bit_reg    <= 1'b0;
      perArm_reg  <= 1'b0;
      tdreArm_reg <= 1'b0;
      rdrfArm_reg <= 1'b0;
      rxData_reg  <= ssp_pkg::RX_DATA_RESET;
      rxHalt_reg  <= 1'b0;
      txHalt_reg  <= 1'b0;
      mpOut_reg   <= 1'b0;
    end
    else
    begin
      per_reg     <= per_next;
      rx_full_flag_reg    <= rx_full_flag_next;
      tx_data_empty_flag_reg    <= tx_data_empty_flag_next;
      tx_end_flag_reg    <= tx_end_flag_next;
      mpb_reg     <= mpb_next;
      tx_multiproc_bit_reg    <= tx_multiproc_bit_next;
      perArm_reg  <= perArm_next;
      tdreArm_reg <= tdreArm_next;
      rdrfArm_reg <= rdrfArm_next;
      rxData_reg  <= rxData_next;
      rxHalt_reg  <= rxHalt_next;
      txHalt_reg  <= txHalt_next;
      mpOut_reg   <= mpOut_next;
    end
  end

  // ****************************************
  // pin control and baud divisor
  // ****************************************
  logic [3:0] pinCtl_reg, pinCtl_next;
  logic [7:0] pinRd_reg, pinRd_next;
  logic [7:0] baud_reg, baud_next;

  always_comb
  begin
    // only power-on reset clears, manual reset and standby keep
    pinCtl_next = pinCtlWrite ? pinCtlWrData[3:0] : pinCtl_reg;
    pinRd_next = {ssp_pkg::PIN_RSVD_READ,
                  pinCtl_reg[ssp_pkg::PIN_CLK_DIR_BIT], sckIn,
                  pinCtl_reg[ssp_pkg::PIN_TXD_DIR_BIT], rxdIn};
    // divisor init on reset and standby
    baud_next = (manualReset || standby) ? ssp_pkg::BAUD_DIV_RESET :
                (baudWrite ? baudWrData : baud_reg);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinCtl_reg <= ssp_pkg::PIN_CTL_RESET;
      pinRd_reg  <= 8'h00;
      baud_reg   <= ssp_pkg::BAUD_DIV_RESET;
    end
    else
    begin
      pinCtl_reg <= pinCtl_next;
      pinRd_reg  <= pinRd_next;
      baud_reg   <= baud_next;
    end
  end

  ssp_baud_gen #(
    .DIV_W (8)
  ) u_baud (
    .clk         (clk),
    .rst         (rst),
    .restart     (baudWrite || manualReset || standby),
    .prescaleSel (prescaleSel),
    .divisor     (baud_reg),
    .syncMode    (syncMode),
    .bitTick     (baudTick)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign statusRdData = {tx_data_empty_flag_reg, rx_full_flag_reg, 2'h0, per_reg, tx_end_flag_reg,
                         mpb_reg, tx_multiproc_bit_reg};
  assign pinCtlRdData = pinRd_reg;
  assign baudDivisor  = baud_reg;
  assign rxDataReg    = rxData_reg;
  assign rxHalt       = rxHalt_reg;
  assign txHalt       = txHalt_reg;
  assign txMpBitOut   = mpOut_reg;
  assign sckOe  = pinCtl_reg[ssp_pkg::PIN_CLK_DIR_BIT];
  assign sckOut = pinCtl_reg[ssp_pkg::PIN_CLK_DATA_BIT];
  assign txdOe  = pinCtl_reg[ssp_pkg::PIN_TXD_DIR_BIT];
  assign txdOut = pinCtl_reg[ssp_pkg::PIN_BRK_DATA_BIT];

  // ****************************************
  // assertions
  // ****************************************
  AST_PER_SET: assert property (@(posedge clk) disable iff (rst)
    charTaken && parityBad && !flagInit |=> per_reg)
    else $error("parity error not flagged");
  AST_PER_NO_FULL: assert property (@(posedge clk) disable iff (rst)
    charTaken && parityBad && !flagInit && !rx_full_flag_reg |=> !rx_full_flag_reg
      && rxData_reg == $past(rxShiftData))
    else $error("parity error char handled wrongly");
  AST_PER_CLR: assert property (@(posedge clk) disable iff (rst)
    statusRead && per_reg ##1 !statusWrite ##1 statusWrite
      && !statusWrData[ssp_pkg::STAT_PER_BIT] |=> !per_reg)
    else $error("parity error not cleared");
  AST_PER_HOLD: assert property (@(posedge clk) disable iff (rst)
    $fell(receiveEnableCtl) && !statusWrite && !flagInit |=>
      per_reg == $past(per_reg))
    else $error("parity error moved on receive disable");
  AST_TX_END_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
    txLastBit && tx_data_empty_flag_reg |=> tx_end_flag_reg)
    else $error("transmit end not set");
  AST_TX_END_FLAG_CLR: assert property (@(posedge clk) disable iff (rst)
    txDataWrite && transmitEnableCtl && !txLastBit && !flagInit |=> !tx_end_flag_reg)
    else $error("transmit end not cleared");
  AST_TX_END_FLAG_RO: assert property (@(posedge clk) disable iff (rst)
    statusWrite && !tx_end_flag_reg && !txLastBit && transmitEnableCtl
      && !flagInit |=> !tx_end_flag_reg)
    else $error("transmit end written");
  AST_MPB_CAP: assert property (@(posedge clk) disable iff (rst)
    charTaken && !syncMode && multiprocMode |=> mpb_reg == $past(rxMpBitIn))
    else $error("multiprocessor bit not captured");
  AST_MPB_HOLD: assert property (@(posedge clk) disable iff (rst)
    !receiveEnableCtl |=> $stable(mpb_reg))
    else $error("multiprocessor bit changed while disabled");
  AST_TX_MULTIPROC_BIT_GATE: assert property (@(posedge clk) disable iff (rst)
    syncMode || !multiprocMode |=> !txMpBitOut)
    else $error("transmit multiprocessor bit leaked");
  AST_PIN_KEEP: assert property (@(posedge clk) disable iff (rst)
    !pinCtlWrite |=> $stable(pinCtl_reg))
    else $error("pin control changed without write");
  AST_PIN_RD: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> pinCtlRdData[7:4] == 4'h0
      && pinCtlRdData[ssp_pkg::PIN_CLK_DATA_BIT] == $past(sckIn)
      && pinCtlRdData[ssp_pkg::PIN_BRK_DATA_BIT] == $past(rxdIn))
    else $error("pin readback wrong");
  AST_TXD_DRV: assert property (@(posedge clk) disable iff (rst)
    pinCtlWrite |=> txdOe == $past(pinCtlWrData[ssp_pkg::PIN_TXD_DIR_BIT])
      && txdOut == $past(pinCtlWrData[ssp_pkg::PIN_BRK_DATA_BIT]))
    else $error("break drive wrong");
  AST_BAUD_INIT: assert property (@(posedge clk) disable iff (rst)
    standby |=> baudDivisor == ssp_pkg::BAUD_DIV_RESET)
    else $error("divisor not reinitialised");
endmodule
`default_nettype wire

// ==== verification/ssp_remote_station.sv ====
`default_nettype none
// ****************************************
// remote serial station on the pins
// ****************************************
module ssp_remote_station (
  input  wire logic clk,
  input  wire logic sckOut,
  input  wire logic sckOe,
  input  wire logic txdOut,
  input  wire logic txdOe,
  input  wire logic rxdDrive,
  output logic      sckLine,
  output logic      txdLine,
  output var logic  rxdLine
);
  timeunit 1ns;
  timeprecision 100ps;
  // pull-ups: a released line reads high, never the last driven value
  assign sckLine = sckOe ? sckOut : 1'b1;
  assign txdLine = txdOe ? txdOut : 1'b1;
  initial rxdLine = 1'b1;
  // station moves its line only just after an edge
  always @(posedge clk)
    rxdLine <= #1 rxdDrive;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst, manualReset, standby, statusRead, statusWrite;
  logic [7:0] statusWrData, statusRdData, pinCtlWrData, pinCtlRdData;
  logic [7:0] baudWrData, baudDivisor, rxShiftData, rxDataReg;
  logic       pinCtlWrite, baudWrite, syncMode, parityEnable, oddParity;
  logic       multiprocMode, receiveEnableCtl, transmitEnableCtl;
  logic [1:0] prescaleSel;
  logic       rxCharDone, rxParityBit, rxMpBitIn, txDataWrite, txLoad;
  logic       txLastBit, rxHalt, txHalt, txMpBitOut, baudTick;
  logic       sckIn, sckOut, sckOe, rxdIn, txdOut, txdOe, txdLine, rxdDrive;
  int         badCount, cmpCount, gap;

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ssp_status_port dut (.clk(clk), .rst(rst), .manualReset(manualReset),
    .standby(standby), .statusRead(statusRead), .statusWrite(statusWrite),
    .statusWrData(statusWrData), .statusRdData(statusRdData),
    .pinCtlWrite(pinCtlWrite), .pinCtlWrData(pinCtlWrData),
    .pinCtlRdData(pinCtlRdData), .baudWrite(baudWrite),
    .baudWrData(baudWrData), .baudDivisor(baudDivisor),
    .syncMode(syncMode), .parityEnable(parityEnable),
    .oddParity(oddParity), .multiprocMode(multiprocMode),
    .prescaleSel(prescaleSel), .receiveEnableCtl(receiveEnableCtl),
    .transmitEnableCtl(transmitEnableCtl), .rxCharDone(rxCharDone),
    .rxShiftData(rxShiftData), .rxParityBit(rxParityBit),
    .rxMpBitIn(rxMpBitIn), .txDataWrite(txDataWrite), .txLoad(txLoad),
    .txLastBit(txLastBit), .rxDataReg(rxDataReg), .rxHalt(rxHalt),
    .txHalt(txHalt), .txMpBitOut(txMpBitOut), .baudTick(baudTick),
    .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .rxdIn(rxdIn),
    .txdOut(txdOut), .txdOe(txdOe));

  ssp_remote_station station (.clk(clk), .sckOut(sckOut), .sckOe(sckOe),
    .txdOut(txdOut), .txdOe(txdOe), .rxdDrive(rxdDrive),
    .sckLine(sckIn), .txdLine(txdLine), .rxdLine(rxdIn));

  task automatic testDone();
    if (badCount == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // inputs move 1 ns after the rising edge, never on it
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic stRd();
    statusRead = 1'b1;
    step();
    statusRead = 1'b0;
    step();
  endtask

  task automatic stWr(input logic [7:0] d);
    statusWrData = d;
    statusWrite = 1'b1;
    step();
    statusWrite = 1'b0;
    step();
  endtask

  task automatic pinWr(input logic [7:0] d);
    pinCtlWrData = d;
    pinCtlWrite = 1'b1;
    step();
    pinCtlWrite = 1'b0;
    step(2);
  endtask

  task automatic baudWr(input logic [7:0] d);
    baudWrData = d;
    baudWrite = 1'b1;
    step();
    baudWrite = 1'b0;
    step();
  endtask

  task automatic rxChar(input logic [7:0] d, input logic p, input logic m);
    rxShiftData = d;
    rxParityBit = p;
    rxMpBitIn = m;
    rxCharDone = 1'b1;
    step();
    rxCharDone = 1'b0;
    step();
  endtask

  // bounded wait for the next tick; a hang ends the run
  task automatic tickGap(output int g);
    int n;
    n = 1;
    step();
    while (baudTick !== 1'b1 && n < 2000)
    begin
      step();
      n++;
    end
    g = n;
    if (n >= 2000)
    begin
      badCount++;
      testDone();
    end
  endtask

  initial
  begin
    {manualReset, standby, statusRead, statusWrite, pinCtlWrite} = '0;
    {baudWrite, syncMode, oddParity, multiprocMode, prescaleSel} = '0;
    {transmitEnableCtl, rxCharDone, rxParityBit, rxMpBitIn} = '0;
    {txDataWrite, txLoad, txLastBit} = '0;
    {statusWrData, pinCtlWrData, baudWrData, rxShiftData} = '0;
    {badCount, cmpCount, gap} = '0;
    parityEnable = 1'b1;
    receiveEnableCtl = 1'b1;
    rxdDrive = 1'b1;
    rst = 1'b1;
    step(4);
    rst = 1'b0;
    step(2);
    chk(statusRdData, 16'h0084);
    chk(baudDivisor, 16'h00FF);
    chk(pinCtlRdData, 16'h0005);
    // parity error: data still lands, receive-full stays low
    rxChar(8'h01, 1'b0, 1'b0);
    chk(statusRdData, 16'h008C);
    chk({rxHalt, rxDataReg}, 16'h0101);
    rxChar(8'h03, 1'b0, 1'b0);
    chk(rxDataReg, 16'h0001);
    receiveEnableCtl = 1'b0;
    step(2);
    chk(statusRdData, 16'h008C);
    receiveEnableCtl = 1'b1;
    stWr(8'hF6);
    chk(statusRdData, 16'h008C);
    stRd();
    stWr(8'hF6);
    chk({rxHalt, statusRdData}, 16'h0084);
    // good multiprocessor character, then receive disabled
    parityEnable = 1'b0;
    multiprocMode = 1'b1;
    rxChar(8'h5A, 1'b0, 1'b1);
    chk({statusRdData, rxDataReg}, 16'hC65A);
    receiveEnableCtl = 1'b0;
    rxChar(8'hA5, 1'b0, 1'b0);
    chk({statusRdData, rxDataReg}, 16'hC65A);
    receiveEnableCtl = 1'b1;
    // software rules: clock modes and transmit off before port use
    // stimulus only drives pins with those controls low
    pinWr(8'h0A);
    chk({txdLine, pinCtlRdData}, 16'h000B);
    rxdDrive = 1'b0;
    step(3);
    chk({sckIn, pinCtlRdData}, 16'h000A);
    baudWr(8'h12);
    chk(baudDivisor, 16'h0012);
    standby = 1'b1;
    step();
    standby = 1'b0;
    step();
    chk({statusRdData, pinCtlRdData}, 16'h860A);
    chk(baudDivisor, 16'h00FF);
    pinWr(8'h00);
    chk({txdLine, pinCtlRdData}, 16'h0104);
    pinWr(8'h02);
    chk(txdLine, 16'h0000);
    pinWr(8'h00);
    // transmit end handling
    transmitEnableCtl = 1'b1;
    txDataWrite = 1'b1;
    step();
    txDataWrite = 1'b0;
    step();
    chk(statusRdData & 8'h04, 16'h0000);
    stWr(8'hCD);
    chk(statusRdData & 8'h04, 16'h0000);
    txLoad = 1'b1;
    step();
    txLoad = 1'b0;
    txLastBit = 1'b1;
    step();
    txLastBit = 1'b0;
    step();
    chk({txMpBitOut, statusRdData & 8'h04}, 16'h0104);
    syncMode = 1'b1;
    step(2);
    chk(txMpBitOut, 16'h0000);
    syncMode = 1'b0;
    stRd();
    stWr(8'h4D);
    chk(statusRdData & 8'h84, 16'h0000);
    transmitEnableCtl = 1'b0;
    step(2);
    chk(statusRdData & 8'h84, 16'h0084);
    // bit timing: sync n=0 N=0, then async n=1 N=1
    syncMode = 1'b1;
    baudWr(8'h00);
    tickGap(gap);
    tickGap(gap);
    chk(gap, 16'd4);
    syncMode = 1'b0;
    prescaleSel = 2'h1;
    baudWr(8'h01);
    tickGap(gap);
    tickGap(gap);
    chk(gap, 16'd256);
    manualReset = 1'b1;
    step();
    manualReset = 1'b0;
    step();
    chk({baudDivisor, pinCtlRdData}, 16'hFF04);
    testDone();
  end
endmodule
`default_nettype wire
